// ---- src/irt_pkg.sv ----
// package for the interrupt routing stage and user offset trim registers
// assumes an 8-bit register port driven by the serial interface logic
package irt_pkg;
  localparam int IRT_AW = 8;
  localparam int IRT_DW = 8;
  localparam int IRT_NSRC = 8;
  localparam logic [IRT_AW-1:0] IRT_OFF_ENABLE = 8'h29;
  localparam logic [IRT_AW-1:0] IRT_OFF_STEER = 8'h2a;
  localparam logic [IRT_AW-1:0] IRT_OFF_PTRIM = 8'h2b;
  localparam logic [IRT_AW-1:0] IRT_OFF_TTRIM = 8'h2c;
  localparam logic [IRT_AW-1:0] IRT_OFF_ATRIM = 8'h2d;
  localparam logic [IRT_AW-1:0] IRT_OFF_POL = 8'h28;
  localparam logic [IRT_DW-1:0] IRT_RST_BYTE = 8'h00;
  // polarity register field positions
  localparam int IRT_POL_A_BIT = 5;
  localparam int IRT_POL_B_BIT = 1;
  // source bit positions in enable, steering and flag vectors
  localparam int IRT_SRC_DRDY = 7;
  localparam int IRT_SRC_FIFO = 6;
  localparam int IRT_SRC_PW = 5;
  localparam int IRT_SRC_TW = 4;
  localparam int IRT_SRC_PTH = 3;
  localparam int IRT_SRC_TTH = 2;
  localparam int IRT_SRC_PCHG = 1;
  localparam int IRT_SRC_TCHG = 0;
  // index of each trim byte inside the trim memory
  localparam logic [1:0] IRT_TRIM_P = 2'h0;
  localparam logic [1:0] IRT_TRIM_T = 2'h1;
  localparam logic [1:0] IRT_TRIM_A = 2'h2;
endpackage

// ---- src/irt_top.sv ----
// interrupt routing stage with per-pin polarity, plus user offset trims
// assumes the serial interface presents single-cycle register strobes
// in the system clock domain; event flags come from same-clock logic
//
// Overview of operation
// RULE1 - a source with steering bit 0 goes to pin b, with bit 1 to pin a.
// RULE2 - the steering register at 2ah holds one bit per source, data ready at bit 7.
// RULE3 - steering bits are read/write and reset to 0, so all sources go to pin b.
// RULE4 - all sources steered to the same pin are ORed together.
// RULE5 - the host reads the source register to learn which source fired.
// RULE6 - pressure trim at 2bh is signed 8-bit at 4 Pa per lsb and is added to pressure.
// RULE7 - temperature trim at 2ch is signed 8-bit at 0.0625 C per lsb, added to temperature.
// RULE8 - altitude trim at 2dh is signed whole meters and is added to altitude.
// RULE9 - all three trims are read/write and reset to zero.
// RULE10 - only enabled sources reach the routing stage.
// RULE11 - each pin has its own polarity, 0 active low and 1 active high.
// RULE12 - a pin follows its enabled flags continuously and drops once all clear.
`timescale 1ns/100ps
module irt_top #(
  parameter int PW = 20,
  parameter int TW = 12,
  parameter int AW = 20
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [irt_pkg::IRT_AW-1:0] i_reg_addr,
  input wire logic [irt_pkg::IRT_DW-1:0] i_reg_wdata,
  output logic [irt_pkg::IRT_DW-1:0] o_reg_rdata,
  input wire logic [irt_pkg::IRT_NSRC-1:0] i_src_flags,
  input wire logic [PW-1:0] i_press_raw,
  input wire logic [TW-1:0] i_temp_raw,
  input wire logic [AW-1:0] i_alt_raw,
  output logic [PW-1:0] o_press_out,
  output logic [TW-1:0] o_temp_out,
  output logic [AW-1:0] o_alt_out,
  output logic o_irq_pin_a,
  output logic o_irq_pin_b
);
  import irt_pkg::*;

  // raw units: pressure 1 Pa/lsb, temperature 0.0625 C/lsb, altitude 1 m/lsb
  localparam int P_SHIFT = 2;

  initial
  begin
    if (PW < 12 || TW < 9 || AW < 9)
      $error("result widths too narrow for trim range");
  end

  typedef struct packed {
    logic [IRT_NSRC-1:0] enable;
    logic [IRT_NSRC-1:0] steer;
    logic pol_a;
    logic pol_b;
    logic [IRT_DW-1:0] rdata;
    logic pin_a;
    logic pin_b;
    logic [PW-1:0] press;
    logic [TW-1:0] temp;
    logic [AW-1:0] alt;
  } irt_st_t;

  irt_st_t st_r;
  irt_st_t st_nxt;

  logic trim_we;
  logic [1:0] trim_waddr;
  logic [1:0] trim_raddr;
  logic [IRT_DW-1:0] trim_rdata;
  logic [3*IRT_DW-1:0] trim_all;
  logic rd_trim_q;

  function automatic logic [1:0] trim_index(input logic [IRT_AW-1:0] a);
    logic [1:0] idx;
    idx = 2'h3;
    if (a == IRT_OFF_PTRIM)
      idx = IRT_TRIM_P;
    else if (a == IRT_OFF_TTRIM)
      idx = IRT_TRIM_T;
    else if (a == IRT_OFF_ATRIM)
      idx = IRT_TRIM_A;
    return idx;
  endfunction

  assign trim_waddr = trim_index(i_reg_addr);
  assign trim_raddr = trim_index(i_reg_addr);
  assign trim_we = i_reg_wr && (trim_waddr != 2'h3); // RULE9

  irt_trim_mem #(
    .DW(IRT_DW),
    .DEPTH(3)
  ) u_trim (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_we(trim_we),
    .i_waddr(trim_waddr),
    .i_wdata(i_reg_wdata),
    .i_raddr(trim_raddr),
    .o_rdata(trim_rdata),
    .o_all(trim_all)
  );

  logic signed [IRT_DW-1:0] p_trim;
  logic signed [IRT_DW-1:0] t_trim;
  logic signed [IRT_DW-1:0] a_trim;
  assign p_trim = trim_all[32'(IRT_TRIM_P)*IRT_DW +: IRT_DW];
  assign t_trim = trim_all[32'(IRT_TRIM_T)*IRT_DW +: IRT_DW];
  assign a_trim = trim_all[32'(IRT_TRIM_A)*IRT_DW +: IRT_DW];

  logic [IRT_NSRC-1:0] live;
  logic to_a;
  logic to_b;
  // enabled flags split by steering bit then ORed per pin
  assign live = i_src_flags & st_r.enable; // RULE10
  assign to_a = |(live & st_r.steer); // RULE1 RULE4
  assign to_b = |(live & ~st_r.steer); // RULE1 RULE4

  always_comb
  begin
    st_nxt = st_r;
    if (i_reg_wr)
    begin
      unique case (i_reg_addr)
        IRT_OFF_ENABLE: st_nxt.enable = i_reg_wdata;
        IRT_OFF_STEER: st_nxt.steer = i_reg_wdata; // RULE2 RULE3
        IRT_OFF_POL:
        begin
          st_nxt.pol_a = i_reg_wdata[IRT_POL_A_BIT];
          st_nxt.pol_b = i_reg_wdata[IRT_POL_B_BIT];
        end
        default: st_nxt.enable = st_r.enable;
      endcase
    end
    st_nxt.rdata = IRT_RST_BYTE;
    if (i_reg_rd)
    begin
      unique case (i_reg_addr)
        IRT_OFF_ENABLE: st_nxt.rdata = st_r.enable;
        IRT_OFF_STEER: st_nxt.rdata = st_r.steer; // RULE3
        IRT_OFF_POL:
        begin
          st_nxt.rdata[IRT_POL_A_BIT] = st_r.pol_a;
          st_nxt.rdata[IRT_POL_B_BIT] = st_r.pol_b;
        end
        default: st_nxt.rdata = IRT_RST_BYTE;
      endcase
    end
    // pin level: asserted level is the polarity bit itself
    st_nxt.pin_a = to_a ? st_r.pol_a : ~st_r.pol_a; // RULE11 RULE12
    st_nxt.pin_b = to_b ? st_r.pol_b : ~st_r.pol_b; // RULE11 RULE12
    // trims sign-extended and added to the results
    st_nxt.press = i_press_raw + PW'({{(PW-IRT_DW){p_trim[IRT_DW-1]}}, p_trim} <<< P_SHIFT); // RULE6
    st_nxt.temp = i_temp_raw + {{(TW-IRT_DW){t_trim[IRT_DW-1]}}, t_trim}; // RULE7
    st_nxt.alt = i_alt_raw + {{(AW-IRT_DW){a_trim[IRT_DW-1]}}, a_trim}; // RULE8
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_r <= '0; // RULE3
      rd_trim_q <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      rd_trim_q <= i_reg_rd && (trim_raddr != 2'h3);
    end
  end

  // trim read comes from the memory's own output register, same latency
  assign o_reg_rdata = rd_trim_q ? trim_rdata : st_r.rdata;
  assign o_irq_pin_a = st_r.pin_a;
  assign o_irq_pin_b = st_r.pin_b;
  assign o_press_out = st_r.press;
  assign o_temp_out = st_r.temp;
  assign o_alt_out = st_r.alt;

  // the host reads the source flags elsewhere; the pins carry no identity (RULE5)
  a_route_to_b: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (|(i_src_flags & st_r.enable & ~st_r.steer)) |=> (o_irq_pin_b == $past(st_r.pol_b)))
    else $error("steered source did not assert pin b"); // RULE1
  a_route_to_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (|(i_src_flags & st_r.enable & st_r.steer)) |=> (o_irq_pin_a == $past(st_r.pol_a)))
    else $error("steered source did not assert pin a"); // RULE4
  a_disabled_quiet: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    // pin was launched with the polarity of the previous cycle
    ((i_src_flags & st_r.enable) == '0)
    |=> (o_irq_pin_a != $past(st_r.pol_a) && o_irq_pin_b != $past(st_r.pol_b)))
    else $error("pin asserted without enabled source"); // RULE10
  a_steer_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_reg_wr && i_reg_addr == IRT_OFF_STEER) |=> (st_r.steer == $past(i_reg_wdata)))
    else $error("steering write lost"); // RULE2
  a_steer_read: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_reg_rd && i_reg_addr == IRT_OFF_STEER && !i_reg_wr) |=> (o_reg_rdata == st_r.steer))
    else $error("steering readback wrong"); // RULE3
  a_trim_read: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_reg_wr && i_reg_addr == IRT_OFF_ATRIM) ##1 (i_reg_rd && !i_reg_wr && i_reg_addr == IRT_OFF_ATRIM)
    |=> (o_reg_rdata == $past(i_reg_wdata, 2)))
    else $error("trim readback wrong"); // RULE9
  a_alt_sum: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    1'b1 |=> (o_alt_out == AW'($past(i_alt_raw) + {{(AW-IRT_DW){$past(a_trim[IRT_DW-1])}}, $past(a_trim)})))
    else $error("altitude trim not applied"); // RULE8
  a_temp_sum: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (t_trim == '0) |=> (o_temp_out == $past(i_temp_raw)))
    else $error("temperature changed with zero trim"); // RULE7
  a_press_step: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (p_trim == 8'h01) |=> (o_press_out == PW'($past(i_press_raw) + 4)))
    else $error("pressure trim weight wrong"); // RULE6
  a_pin_release: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!to_b && $past(to_b)) |=> (o_irq_pin_b != $past(st_r.pol_b)))
    else $error("pin b held after flags cleared"); // RULE12
  a_pol_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!to_a) |=> (o_irq_pin_a == ~$past(st_r.pol_a)))
    else $error("idle level ignores polarity"); // RULE11

  c_pin_a: cover property (@(posedge i_sys_clk) disable iff (i_rst) to_a && st_r.pol_a);
  c_pin_b: cover property (@(posedge i_sys_clk) disable iff (i_rst) to_b && !st_r.pol_b);
  c_both: cover property (@(posedge i_sys_clk) disable iff (i_rst) to_a && to_b);
  c_neg_trim: cover property (@(posedge i_sys_clk) disable iff (i_rst) p_trim[IRT_DW-1]);
endmodule

// ---- src/irt_trim_mem.sv ----
// small register memory holding the three signed trim bytes
// assumes single clock, one write port, registered read port
`timescale 1ns/100ps
module irt_trim_mem #(
  parameter int DW = 8,
  parameter int DEPTH = 3
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic [1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [1:0] i_raddr,
  output logic [DW-1:0] o_rdata,
  output logic [DEPTH*DW-1:0] o_all
);
  import irt_pkg::*;

  initial
  begin
    if (DEPTH < 1 || DEPTH > 4)
      $error("trim memory depth out of range");
  end

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0] rd;
  } irt_mem_st_t;

  irt_mem_st_t st_r;
  irt_mem_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (i_we && 32'(i_waddr) < DEPTH)
      st_nxt.mem[i_waddr] = i_wdata;
    st_nxt.rd = (32'(i_raddr) < DEPTH) ? st_r.mem[i_raddr] : '0;
  end

  // trims clear to zero so no correction applies until written
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      st_r <= '0; // RULE9
    else
      st_r <= st_nxt;
  end

  assign o_rdata = st_r.rd;
  assign o_all = st_r.mem;
endmodule

// ---- tb/irq_routing_and_offset_trim_test.sv ----
// self-checking bench for the routing stage and the trim registers
// assumes default widths: 20-bit pressure and altitude, 12-bit temperature
`timescale 1ns/100ps
module irq_routing_and_offset_trim_test;
  import irt_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] flags = 8'h00;
  logic [19:0] pr = 20'h00000;
  logic [19:0] ar = 20'h00000;
  logic [11:0] tr = 12'h000;
  logic [19:0] po, ao;
  logic [11:0] tp;
  logic [7:0] rdata, addr, wdata, d;
  logic wr, rd, pa, pb;
  int error_cnt = 0;
  int num_checks = 0;
  always #2 clk = ~clk;
  irt_host_model i_irt_host_model (.i_sys_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
    .o_addr(addr), .o_wdata(wdata));
  irt_top i_irt_top (.i_sys_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_src_flags(flags),
    .i_press_raw(pr), .i_temp_raw(tr), .i_alt_raw(ar), .o_press_out(po), .o_temp_out(tp),
    .o_alt_out(ao), .o_irq_pin_a(pa), .o_irq_pin_b(pb));
  task automatic chk(string n, logic [19:0] e, logic [19:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  // pins are registered: one edge after the last cause changed
  task automatic pins(logic ea, logic eb);
    @(posedge clk);
    #1;
    chk("irq_pin_a", {19'h0, ea}, {19'h0, pa});
    chk("irq_pin_b", {19'h0, eb}, {19'h0, pb});
  endtask
  task automatic rchk(logic [7:0] a, logic [7:0] e);
    i_irt_host_model.rd(a, d);
    chk("reg_read", {12'h0, e}, {12'h0, d});
  endtask
  task automatic t_reset();
    chk("idle_pins", 20'h3, {18'h0, pa, pb});
    for (int a = 8'h28; a <= 8'h2d; a++)
      rchk(8'(a), IRT_RST_BYTE);
  endtask
  task automatic t_route();
    logic [7:0] m;
    i_irt_host_model.wr(IRT_OFF_ENABLE, 8'hff);
    i_irt_host_model.wr(IRT_OFF_POL, 8'h22);
    for (int i = 0; i < 8; i++)
    begin
      m = 8'h01 << i;
      i_irt_host_model.wr(IRT_OFF_STEER, m);
      flags = m;
      pins(1'b1, 1'b0);
      i_irt_host_model.wr(IRT_OFF_STEER, 8'h00);
      pins(1'b0, 1'b1);
      flags = 8'h00;
    end
    rchk(IRT_OFF_STEER, 8'h00);
  endtask
  task automatic t_or();
    i_irt_host_model.wr(IRT_OFF_STEER, 8'h0f);
    flags = 8'h03;
    pins(1'b1, 1'b0);
    flags = 8'h31;
    pins(1'b1, 1'b1);
    flags = 8'h01;
    pins(1'b1, 1'b0);
    flags = 8'h00;
    pins(1'b0, 1'b0);
  endtask
  task automatic t_enable_pol();
    i_irt_host_model.wr(IRT_OFF_ENABLE, 8'h0f);
    flags = 8'hf0;
    pins(1'b0, 1'b0);
    i_irt_host_model.wr(IRT_OFF_POL, 8'h02);
    flags = 8'h01;
    pins(1'b0, 1'b0);
    flags = 8'h00;
    pins(1'b1, 1'b0);
    rchk(IRT_OFF_POL, 8'h02);
    rchk(IRT_OFF_ENABLE, 8'h0f);
  endtask
  // extreme trims: most negative pressure, most positive temperature
  task automatic t_trim();
    pr = 20'h01000;
    tr = 12'h100;
    ar = 20'h00010;
    i_irt_host_model.wr(IRT_OFF_PTRIM, 8'h80);
    i_irt_host_model.wr(IRT_OFF_TTRIM, 8'h7f);
    i_irt_host_model.wr(IRT_OFF_ATRIM, 8'hff);
    @(posedge clk);
    #1;
    chk("press_out", pr - 20'd512, po);
    chk("temp_out", {8'h0, tr + 12'd127}, {8'h0, tp});
    chk("alt_out", ar - 20'd1, ao);
    rchk(IRT_OFF_PTRIM, 8'h80);
    rchk(IRT_OFF_TTRIM, 8'h7f);
    rchk(IRT_OFF_ATRIM, 8'hff);
    rchk(8'h30, 8'h00);
    i_irt_host_model.wr_rd(IRT_OFF_ATRIM, 8'h81, d);
    chk("atrim_wr_rd", 20'h00081, {12'h0, d});
    i_irt_host_model.wr(IRT_OFF_PTRIM, 8'h01);
    @(posedge clk);
    #1;
    chk("press_step", pr + 20'd4, po);
    chk("alt_neg", ar - 20'd127, ao);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_route();
    t_or();
    t_enable_pol();
    t_trim();
    stop_test();
  end
  // whole run is about 125 cycles; far beyond that means a hang
  initial
  begin
    #20000;
    error_cnt++;
    stop_test();
  end
endmodule

// ---- tb/irt_host_model.sv ----
// host side model: the register master that sits across the serial link
// assumes the block takes strobes on the rising edge of i_sys_clk
`timescale 1ns/100ps
module irt_host_model (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // one-cycle strobe, data held until the taking edge has passed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    #1;
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_sys_clk);
    #1;
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
  // write then read the same address on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d);
    @(posedge i_sys_clk);
    #1;
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = wd;
    @(posedge i_sys_clk);
    #1;
    o_wr = 1'b0;
    o_rd = 1'b1;
    @(posedge i_sys_clk);
    #1;
    o_rd = 1'b0;
    o_wdata = ~wd;
    d = i_rdata;
  endtask
  // pins carry no source id, so causes are learned by register reads
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    #1;
    o_rd = 1'b1;
    o_addr = a;
    @(posedge i_sys_clk);
    #1;
    o_rd = 1'b0;
    d = i_rdata;
  endtask
endmodule
